// ===== hw/rfc_pkg.sv
package rfc_pkg;

    // ==========================================================
    // Operation control register and its fields
    localparam logic [7:0] OPCTL_ADDR  = 8'h01;
    localparam logic [7:0] OPCTL_RESET = 8'h00;
    localparam int         TRIG_BIT    = 4;
    localparam int         PERM_BIT    = 5;
    localparam int         PRE_BIT     = 6;

    // ==========================================================
    // Command opcodes and field sizes
    localparam logic [2:0] OP_CFG         = 3'h0;
    localparam logic [2:0] OP_READ        = 3'h1;
    localparam logic [2:0] OP_WRITE       = 3'h2;
    localparam logic [2:0] OP_ACTION      = 3'h3;
    localparam logic [2:0] OP_LAST        = 3'h3;
    localparam int         DATA_W         = 32;
    localparam int         CHARS_PER_BYTE = 2;

    // Answer codes sent back to the host
    typedef enum logic [3:0] {
        RSP_Q0  = 4'h0,
        RSP_Q1  = 4'h1,
        RSP_Q2  = 4'h2,
        RSP_Q4  = 4'h4,
        RSP_Q5  = 4'h5,
        RSP_E01 = 4'h8,
        RSP_E02 = 4'h9,
        RSP_E04 = 4'ha,
        RSP_E08 = 4'hb,
        RSP_E10 = 4'hc
    } rfc_code_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_PRECHG = 3'b001,
        ST_WRITE  = 3'b010,
        ST_VERIFY = 3'b011,
        ST_READ   = 3'b100,
        ST_RDWAIT = 3'b101
    } rfc_state_t;

    // Decoded command from the link front end
    typedef struct packed {
        logic              valid;
        logic [2:0]        op;
        logic [7:0]        addr;
        logic [DATA_W-1:0] data;
        logic [7:0]        start_blk;
        logic [7:0]        blk_cnt;
        logic [7:0]        byte_len;
        logic [8:0]        chars;
        logic              frame_err;
        logic              bad_char;
        logic              crc_bad;
    } rfc_cmd_t;

    // Transponder stage status
    typedef struct packed {
        logic              present;
        logic              wr_done;
        logic              rd_done;
        logic [DATA_W-1:0] rd_data;
        logic [7:0]        blocks;
    } rfc_tag_in_t;

    // Transponder stage requests
    typedef struct packed {
        logic              wr_req;
        logic              rd_req;
        logic [7:0]        start_blk;
        logic [7:0]        blk_cnt;
        logic [DATA_W-1:0] data;
    } rfc_tag_out_t;

    // Answer to the host
    typedef struct packed {
        logic              valid;
        rfc_code_t         code;
        logic [DATA_W-1:0] data;
    } rfc_rsp_t;

endpackage

// ===== hw/rfc_checker.sv
// Operation
// R1: Precharge may be stored enabled only when trigger is enabled in the same byte.
// R2: Continuous reading is valid only when trigger and precharge are both off.
// R3: A contradictory configuration answers E10 and leaves the stored value unchanged.
// R4: Unexecutable commands answer Q0, accepted configuration Q1, done actions Q2.
// R5: With precharge on, write data is stored before any tag and answered with Q4.
// R6: A tag entering the field while precharged data is held is written automatically.
// R7: Every write is read back and Q5 is sent only after the data compares equal.
// R8: Faulty commands answer E01 unknown, E02 bad parameter, E04 framing fault.
// R9: A block range beyond the tag's memory answers with an error instead of access; the code answers Q0.
// R10: Tag reading is suspended while the switching output is active.
// R11: With checksum protection on, a bad checksum discards the command with E08.
// R12: Data must hold two characters per byte, otherwise E02 is returned.
`timescale 1ns/100ps
`default_nettype none
module rfc_checker
(
    // Clock and reset
    input  wire logic                  I_CORE_CLK,
    input  wire logic                  I_RST,
    // Host command side
    input  wire rfc_pkg::rfc_cmd_t     I_CMD,
    input  wire logic                  I_CRC_EN,
    output var  rfc_pkg::rfc_rsp_t     O_RSP,
    output logic                       O_BUSY,
    output logic [7:0]                 O_OPCTL,
    // Transponder stage
    input  wire rfc_pkg::rfc_tag_in_t  I_TAG,
    input  wire logic                  I_OUT_ACTIVE,
    output var  rfc_pkg::rfc_tag_out_t O_TAG
);

    // ==========================================================
    // State record
    typedef struct packed {
        rfc_pkg::rfc_state_t           state;
        logic [7:0]                    cfg;
        logic [rfc_pkg::DATA_W-1:0]    wdata;
        logic [7:0]                    start_blk;
        logic [7:0]                    blk_cnt;
        logic                          busy;
        rfc_pkg::rfc_rsp_t             rsp;
        rfc_pkg::rfc_tag_out_t         tag;
    } rfc_st_t;

    localparam rfc_st_t ST_RESET = '{
        state: rfc_pkg::ST_IDLE,
        cfg:   rfc_pkg::OPCTL_RESET,
        rsp:   '{valid: 1'b0, code: rfc_pkg::RSP_Q0, data: '0},
        default: '0
    };

    rfc_st_t r;
    rfc_st_t nxt;

    // Consistency of a configuration byte, used in decode and checks
    function automatic logic cfg_ok(input logic [7:0] c);
        logic trig;
        logic perm;
        logic pre;
        trig = c[rfc_pkg::TRIG_BIT];
        perm = c[rfc_pkg::PERM_BIT];
        pre  = c[rfc_pkg::PRE_BIT];
        cfg_ok = (!pre || trig) && (!perm || (!trig && !pre)); // R1 R2
    endfunction

    // ==========================================================
    // Command screening
    logic             cmd_take;
    logic             len_bad;
    logic             range_bad;
    logic             clean;
    logic [8:0]       blk_end;
    rfc_pkg::rfc_code_t err_code;

    // Screening is combinational so that an answer follows one cycle later unless a tag read or write starts
    assign cmd_take  = I_CMD.valid && !r.busy;
    assign len_bad   = I_CMD.chars != 9'(I_CMD.byte_len * rfc_pkg::CHARS_PER_BYTE); // R12
    assign blk_end   = {1'b0, I_CMD.start_blk} + {1'b0, I_CMD.blk_cnt};
    assign range_bad = blk_end > {1'b0, I_TAG.blocks}; // R9

    // Earlier faults take priority: framing, checksum, opcode, parameter
    always_comb
    begin
        clean    = 1'b0;
        err_code = rfc_pkg::RSP_Q0;
        if (I_CMD.frame_err)
            err_code = rfc_pkg::RSP_E04; // R8
        else if (I_CRC_EN && I_CMD.crc_bad)
            err_code = rfc_pkg::RSP_E08; // R11
        else if (I_CMD.op > rfc_pkg::OP_LAST)
            err_code = rfc_pkg::RSP_E01; // R8
        else if (I_CMD.bad_char || len_bad)
            err_code = rfc_pkg::RSP_E02; // R8 R12
        else
            clean = 1'b1;
    end

    // ==========================================================
    // Sequencer
    always_comb
    begin
        nxt            = r;
        nxt.rsp.valid  = 1'b0;
        nxt.tag.wr_req = 1'b0;
        nxt.tag.rd_req = 1'b0;
        unique case (r.state)
            rfc_pkg::ST_IDLE, rfc_pkg::ST_PRECHG:
            begin
                if (cmd_take)
                begin
                    nxt.rsp.valid = 1'b1;
                    nxt.rsp.data  = '0;
                    nxt.rsp.code  = err_code;
                    if (clean)
                    begin
                        unique case (I_CMD.op)
                            rfc_pkg::OP_CFG:
                            begin
                                if (I_CMD.addr != rfc_pkg::OPCTL_ADDR)
                                    nxt.rsp.code = rfc_pkg::RSP_Q0; // R4
                                else if (!cfg_ok(I_CMD.data[7:0]))
                                    nxt.rsp.code = rfc_pkg::RSP_E10; // R3
                                else
                                begin
                                    nxt.cfg      = I_CMD.data[7:0];
                                    nxt.rsp.code = rfc_pkg::RSP_Q1; // R4
                                end
                            end
                            rfc_pkg::OP_ACTION:
                                nxt.rsp.code = rfc_pkg::RSP_Q2; // R4
                            default:
                            begin
                                nxt.start_blk = I_CMD.start_blk;
                                nxt.blk_cnt   = I_CMD.blk_cnt;
                                nxt.wdata     = I_CMD.data;
                                if (range_bad)
                                    nxt.rsp.code = rfc_pkg::RSP_Q0; // R9
                                else if (I_CMD.op == rfc_pkg::OP_READ)
                                begin
                                    nxt.rsp.valid = 1'b0;
                                    nxt.state     = rfc_pkg::ST_READ;
                                    nxt.busy      = 1'b1;
                                end
                                else if (r.cfg[rfc_pkg::PRE_BIT])
                                begin
                                    nxt.rsp.code = rfc_pkg::RSP_Q4; // R5
                                    nxt.state    = rfc_pkg::ST_PRECHG;
                                end
                                else if (I_TAG.present)
                                begin
                                    nxt.rsp.valid = 1'b0;
                                    nxt.state     = rfc_pkg::ST_WRITE;
                                    nxt.busy      = 1'b1;
                                end
                                else
                                    nxt.rsp.code = rfc_pkg::RSP_Q0; // R4
                            end
                        endcase
                    end
                end
                else if (r.state == rfc_pkg::ST_PRECHG && I_TAG.present)
                begin
                    nxt.state = rfc_pkg::ST_WRITE; // R6
                    nxt.busy  = 1'b1;
                end
            end
            rfc_pkg::ST_WRITE:
            begin
                // Write is launched once, then the done strobe is awaited
                nxt.tag.start_blk = r.start_blk;
                nxt.tag.blk_cnt   = r.blk_cnt;
                nxt.tag.data      = r.wdata;
                nxt.tag.wr_req    = 1'b1; // R6
                nxt.state         = rfc_pkg::ST_VERIFY;
            end
            rfc_pkg::ST_VERIFY:
            begin
                // Read back only after the write finished and the output is quiet
                if (I_TAG.wr_done && !I_OUT_ACTIVE)
                begin
                    nxt.tag.rd_req = 1'b1; // R7 R10
                    nxt.state      = rfc_pkg::ST_RDWAIT;
                    nxt.wdata      = r.wdata;
                    nxt.start_blk  = 8'hff;
                end
            end
            rfc_pkg::ST_READ:
            begin
                // Reading waits out the switching output period
                if (!I_TAG.present)
                begin
                    nxt.rsp.valid = 1'b1;
                    nxt.rsp.code  = rfc_pkg::RSP_Q0;
                    nxt.state     = rfc_pkg::ST_IDLE;
                    nxt.busy      = 1'b0;
                end
                else if (!I_OUT_ACTIVE)
                begin
                    nxt.tag.start_blk = r.start_blk;
                    nxt.tag.blk_cnt   = r.blk_cnt;
                    nxt.tag.rd_req    = 1'b1; // R10
                    nxt.state         = rfc_pkg::ST_RDWAIT;
                end
            end
            rfc_pkg::ST_RDWAIT:
            begin
                // start_blk of all ones marks a verify read
                if (I_TAG.rd_done)
                begin
                    nxt.rsp.valid = 1'b1;
                    nxt.rsp.data  = I_TAG.rd_data;
                    nxt.state     = rfc_pkg::ST_IDLE;
                    nxt.busy      = 1'b0;
                    if (r.start_blk != 8'hff)
                        nxt.rsp.code = rfc_pkg::RSP_Q2; // R4
                    else if (I_TAG.rd_data == r.wdata)
                        nxt.rsp.code = rfc_pkg::RSP_Q5; // R7
                    else
                        nxt.rsp.code = rfc_pkg::RSP_Q0;
                end
            end
            default:
                nxt = ST_RESET;
        endcase
    end

    // Single register bank for the whole state record
    always_ff @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
            r <= ST_RESET;
        else
            r <= nxt;
    end

    // Outputs come straight from the state record
    assign O_RSP   = r.rsp;
    assign O_TAG   = r.tag;
    assign O_BUSY  = r.busy;
    assign O_OPCTL = r.cfg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    property p_pre_trig;
        r.cfg[rfc_pkg::PRE_BIT] |-> r.cfg[rfc_pkg::TRIG_BIT];
    endproperty
    a_pre_trig: assert property (p_pre_trig) else $error("precharge without trigger"); // R1

    property p_perm_alone;
        r.cfg[rfc_pkg::PERM_BIT] |-> !r.cfg[rfc_pkg::TRIG_BIT] && !r.cfg[rfc_pkg::PRE_BIT];
    endproperty
    a_perm_alone: assert property (p_perm_alone) else $error("continuous read mixed"); // R2

    property p_e10_keep;
        r.rsp.valid && r.rsp.code == rfc_pkg::RSP_E10 |-> r.cfg == $past(r.cfg);
    endproperty
    a_e10_keep: assert property (p_e10_keep) else $error("config changed on E10"); // R3

    property p_q1_store;
        cmd_take && clean && I_CMD.op == rfc_pkg::OP_CFG
            && I_CMD.addr == rfc_pkg::OPCTL_ADDR && cfg_ok(I_CMD.data[7:0])
            |=> r.rsp.valid && r.rsp.code == rfc_pkg::RSP_Q1 && r.cfg == $past(I_CMD.data[7:0]);
    endproperty
    a_q1_store: assert property (p_q1_store) else $error("config not stored with Q1"); // R4

    property p_q4_hold;
        r.rsp.valid && r.rsp.code == rfc_pkg::RSP_Q4 |-> r.state == rfc_pkg::ST_PRECHG;
    endproperty
    a_q4_hold: assert property (p_q4_hold) else $error("Q4 without held data"); // R5

    property p_auto_write;
        r.state == rfc_pkg::ST_PRECHG && I_TAG.present && !cmd_take |=> ##1 r.tag.wr_req;
    endproperty
    a_auto_write: assert property (p_auto_write) else $error("precharged write missing"); // R6

    property p_q5_verified;
        r.rsp.valid && r.rsp.code == rfc_pkg::RSP_Q5
            |-> $past(I_TAG.rd_done) && $past(I_TAG.rd_data) == $past(r.wdata);
    endproperty
    a_q5_verified: assert property (p_q5_verified) else $error("Q5 without readback"); // R7

    property p_frame;
        cmd_take && I_CMD.frame_err |=> r.rsp.valid && r.rsp.code == rfc_pkg::RSP_E04;
    endproperty
    a_frame: assert property (p_frame) else $error("framing fault not E04"); // R8

    property p_range;
        cmd_take && clean && I_CMD.op == rfc_pkg::OP_READ && range_bad
            |=> r.rsp.valid && r.rsp.code == rfc_pkg::RSP_Q0 && !r.busy;
    endproperty
    a_range: assert property (p_range) else $error("out of range access"); // R9

    property p_suspend;
        $past(I_OUT_ACTIVE) |-> !r.tag.rd_req;
    endproperty
    a_suspend: assert property (p_suspend) else $error("read during output"); // R10

    property p_crc;
        cmd_take && !I_CMD.frame_err && I_CRC_EN && I_CMD.crc_bad
            |=> r.rsp.code == rfc_pkg::RSP_E08 && $stable(r.cfg);
    endproperty
    a_crc: assert property (p_crc) else $error("checksum fault not E08"); // R11

    property p_len;
        cmd_take && len_bad && !I_CMD.frame_err && !(I_CRC_EN && I_CMD.crc_bad)
            && I_CMD.op <= rfc_pkg::OP_LAST |=> r.rsp.code == rfc_pkg::RSP_E02;
    endproperty
    a_len: assert property (p_len) else $error("length mismatch not E02"); // R12

endmodule
`default_nettype wire

// ===== test/rfc_tag_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// Transponder stage: answers write and read requests after a set latency
module rfc_tag_model
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Requests from the block
    input  wire rfc_pkg::rfc_tag_out_t tag_out,
    // Field conditions chosen by the bench
    input  wire logic                  present,
    input  wire logic [7:0]            blocks,
    input  wire logic [3:0]            lat,
    input  wire logic                  corrupt,
    // Status back to the block
    output var  rfc_pkg::rfc_tag_in_t  tag_in
);
    logic [31:0] mem_r;
    logic [31:0] rd_r;
    logic [1:0]  pend_r;
    logic [3:0]  cnt_r;
    logic        wd_r;
    logic        rdd_r;

    // Read data outside its pulse toggles, so a stale sample never matches
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_r  <= 32'h0;
            rd_r   <= 32'h5a5a5a5a;
            pend_r <= 2'h0;
            cnt_r  <= 4'h0;
            wd_r   <= 1'b0;
            rdd_r  <= 1'b0;
        end
        else
        begin
            wd_r  <= 1'b0;
            rdd_r <= 1'b0;
            rd_r  <= ~rd_r;
            if (tag_out.wr_req)
            begin
                mem_r  <= tag_out.data;
                pend_r <= 2'h1;
                cnt_r  <= lat;
            end
            else if (tag_out.rd_req)
            begin
                pend_r <= 2'h2;
                cnt_r  <= lat;
            end
            else if (pend_r != 2'h0 && cnt_r != 4'h0)
                cnt_r <= cnt_r - 4'h1;
            else if (pend_r != 2'h0)
            begin
                pend_r <= 2'h0;
                wd_r   <= (pend_r == 2'h1);
                rdd_r  <= (pend_r == 2'h2);
                if (pend_r == 2'h2)
                    rd_r <= corrupt ? ~mem_r : mem_r;
            end
        end
    end

    // Status bundle
    always_comb
    begin
        tag_in.present = present;
        tag_in.wr_done = wd_r;
        tag_in.rd_done = rdd_r;
        tag_in.rd_data = rd_r;
        tag_in.blocks  = blocks;
    end
endmodule
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                  clk;
    logic                  rst;
    logic                  crc_en;
    logic                  out_active;
    logic                  present;
    logic                  corrupt;
    logic [3:0]            lat;
    logic                  busy;
    logic [7:0]            opctl;
    logic [7:0]            cfg;
    logic [7:0]            prev;
    logic [31:0]           wdat;
    rfc_pkg::rfc_cmd_t     cmd;
    rfc_pkg::rfc_cmd_t     c;
    rfc_pkg::rfc_rsp_t     rsp;
    rfc_pkg::rfc_rsp_t     got;
    rfc_pkg::rfc_tag_in_t  tag_in;
    rfc_pkg::rfc_tag_out_t tag_out;
    rfc_pkg::rfc_code_t    ecode [6];
    int                    failures;
    int                    checks_done;
    int                    cycles;
    int                    seen;

    // ====
    // Design and transponder stage
    rfc_checker u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CMD(cmd), .I_CRC_EN(crc_en),
        .O_RSP(rsp), .O_BUSY(busy), .O_OPCTL(opctl), .I_TAG(tag_in),
        .I_OUT_ACTIVE(out_active), .O_TAG(tag_out));
    rfc_tag_model u_tag (.clk(clk), .rst(rst), .tag_out(tag_out), .present(present),
        .blocks(8'h10), .lat(lat), .corrupt(corrupt), .tag_in(tag_in));

    // Clock and hang guard; the longest path is well under this
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            wrap_up();
        end
    end

    // ====
    // Helpers
    task automatic check(logic [63:0] sv, logic [63:0] ev, string what);
        checks_done++;
        if (sv !== ev)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, sv, ev);
        end
    endtask

    task automatic send(rfc_pkg::rfc_cmd_t x);
        @(posedge clk);
        #1;
        cmd = x;
        cmd.valid = 1'b1;
        @(posedge clk);
        #1;
        cmd.valid = 1'b0;
    endtask

    // Answers are one-cycle pulses, so they are looked at on the falling edge
    task automatic expect_rsp(rfc_pkg::rfc_code_t code);
        int n;
        n = 0;
        @(negedge clk);
        while (rsp.valid !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        got = rsp;
        check({63'h0, got.valid}, 64'h1, "answer present");
        check({60'h0, got.code}, {60'h0, code}, "answer code");
    endtask

    // Counts request pulses or answers over a quiet stretch
    task automatic quiet(int len);
        seen = 0;
        repeat (len)
        begin
            @(negedge clk);
            seen += int'(tag_out.rd_req !== 1'b0 || tag_out.wr_req !== 1'b0 || rsp.valid !== 1'b0);
        end
    endtask

    function automatic rfc_pkg::rfc_cmd_t mk(logic [2:0] op, logic [31:0] d, logic [7:0] sb,
        logic [7:0] bc);
        rfc_pkg::rfc_cmd_t r;
        r = '0;
        r.op = op;
        r.addr = rfc_pkg::OPCTL_ADDR;
        r.data = d;
        r.start_blk = sb;
        r.blk_cnt = bc;
        r.byte_len = 8'h04;
        r.chars = 9'h008;
        return r;
    endfunction

    function automatic logic cfg_ok(logic [7:0] b);
        return !(b[rfc_pkg::PRE_BIT] && !b[rfc_pkg::TRIG_BIT])
            && !(b[rfc_pkg::PERM_BIT] && (b[rfc_pkg::TRIG_BIT] || b[rfc_pkg::PRE_BIT]));
    endfunction

    task automatic wrap_up();
        $display("Summary: %0d checks, %0d failures", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ====
    // Main sequence
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        crc_en = 1'b0;
        out_active = 1'b0;
        present = 1'b1;
        corrupt = 1'b0;
        lat = 4'h2;
        cmd = '0;
        failures = 0;
        checks_done = 0;
        cycles = 0;
        ecode = '{rfc_pkg::RSP_E04, rfc_pkg::RSP_E08, rfc_pkg::RSP_E01, rfc_pkg::RSP_E02,
            rfc_pkg::RSP_E02, rfc_pkg::RSP_Q2};
        void'($urandom(37));
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        check({55'h0, busy, opctl}, {55'h0, 1'b0, rfc_pkg::OPCTL_RESET}, "reset state");
        // All trigger/continuous/precharge combinations first, then random bytes
        for (int i = 0; i < 24; i++)
        begin
            cfg = 8'($urandom);
            if (i < 8)
                cfg[6:4] = i[2:0];
            prev = opctl;
            send(mk(rfc_pkg::OP_CFG, {24'h0, cfg}, 8'h0, 8'h0));
            expect_rsp(cfg_ok(cfg) ? rfc_pkg::RSP_Q1 : rfc_pkg::RSP_E10);
            @(negedge clk);
            check({56'h0, opctl}, {56'h0, cfg_ok(cfg) ? cfg : prev}, "stored config");
        end
        c = mk(rfc_pkg::OP_CFG, 32'h10, 8'h0, 8'h0);
        c.addr = 8'h02;
        send(c);
        expect_rsp(rfc_pkg::RSP_Q0);
        send(mk(rfc_pkg::OP_CFG, 32'h0, 8'h0, 8'h0));
        expect_rsp(rfc_pkg::RSP_Q1);
        // Fault flags in priority order, last one a bad checksum while unprotected
        for (int i = 0; i < 6; i++)
        begin
            c = mk((i == 2) ? 3'h5 : rfc_pkg::OP_ACTION, 32'h0, 8'h0, 8'h0);
            c.frame_err = (i == 0);
            c.crc_bad = (i < 2) || (i == 5);
            c.bad_char = (i == 2) || (i == 3);
            c.chars = (i == 4) ? 9'h007 : 9'h008;
            crc_en = (i != 5);
            send(c);
            expect_rsp(ecode[i]);
        end
        // Write with read-back, good then corrupted, then with no tag
        for (int i = 0; i < 3; i++)
        begin
            lat = 4'($urandom_range(7, 0));
            corrupt = (i == 1);
            present = (i != 2);
            if (i != 2)
                wdat = $urandom;
            send(mk(rfc_pkg::OP_WRITE, (i == 2) ? ~wdat : wdat, 8'h0, 8'h4));
            expect_rsp((i == 0) ? rfc_pkg::RSP_Q5 : rfc_pkg::RSP_Q0);
        end
        corrupt = 1'b0;
        present = 1'b1;
        // Read held off by the switching output; a command while busy is ignored
        out_active = 1'b1;
        send(mk(rfc_pkg::OP_READ, 32'h0, 8'h0a, 8'h06));
        send(mk(rfc_pkg::OP_CFG, 32'h10, 8'h0, 8'h0));
        quiet(10);
        check(64'(seen), 64'h0, "activity while output active");
        out_active = 1'b0;
        expect_rsp(rfc_pkg::RSP_Q2);
        check({32'h0, got.data}, {32'h0, wdat}, "read data");
        check({56'h0, opctl}, 64'h0, "config while busy");
        // One block past the end of the tag's memory
        send(mk(rfc_pkg::OP_READ, 32'h0, 8'h0a, 8'h07));
        expect_rsp(rfc_pkg::RSP_Q0);
        send(mk(rfc_pkg::OP_WRITE, 32'h1, 8'h0f, 8'h02));
        expect_rsp(rfc_pkg::RSP_Q0);
        // Precharged write runs by itself once a tag shows up
        send(mk(rfc_pkg::OP_CFG, 32'h50, 8'h0, 8'h0));
        expect_rsp(rfc_pkg::RSP_Q1);
        present = 1'b0;
        wdat = $urandom;
        send(mk(rfc_pkg::OP_WRITE, wdat, 8'h0, 8'h4));
        expect_rsp(rfc_pkg::RSP_Q4);
        quiet(6);
        check(64'(seen), 64'h0, "write before tag");
        present = 1'b1;
        expect_rsp(rfc_pkg::RSP_Q5);
        check({32'h0, tag_out.data}, {32'h0, wdat}, "precharged data");
        wrap_up();
    end
endmodule
`default_nettype wire
